/* sct_pkg.sv */
package sct_pkg;
	// ------------------------------------------------------------
	// Register map of the Wishbone slave (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] SCT_OFF_CTRL = 8'h00;
	localparam logic [7:0] SCT_OFF_VEC = 8'h04;
	localparam logic [7:0] SCT_OFF_ACC = 8'h08;
	localparam logic [7:0] SCT_OFF_PTRS = 8'h0C;
	localparam int SCT_CTRL_RUN = 0;
	localparam int SCT_CTRL_PINC = 1;
	localparam logic [15:0] SCT_VEC_RST = 16'hFFFC;
	localparam logic [15:0] SCT_PC_RST = 16'h0000;
	localparam logic [15:0] SCT_SP_RST = 16'h00FF;

	// ------------------------------------------------------------
	// Flags register layout and reset value
	// ------------------------------------------------------------
	localparam int SCT_F_V = 7;
	localparam int SCT_F_H = 4;
	localparam int SCT_F_I = 3;
	localparam int SCT_F_N = 2;
	localparam int SCT_F_Z = 1;
	localparam int SCT_F_C = 0;
	localparam logic [7:0] SCT_CCR_RST = 8'h68;

	// ------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] SCT_OP_PREFIX = 8'h9E;
	localparam logic [7:0] SCT_OP_SUB_LIT = 8'hA0;
	localparam logic [7:0] SCT_OP_SUB_PG0 = 8'hB0;
	localparam logic [7:0] SCT_OP_SUB_ABS = 8'hC0;
	localparam logic [7:0] SCT_OP_SUB_O16 = 8'hD0;
	localparam logic [7:0] SCT_OP_SUB_O8 = 8'hE0;
	localparam logic [7:0] SCT_OP_SUB_PTR = 8'hF0;
	localparam logic [7:0] SCT_OP_SOFT_TRAP = 8'h83;
	localparam logic [7:0] SCT_OP_ACC_TO_FLAGS = 8'h84;
	localparam logic [7:0] SCT_OP_FLAGS_TO_ACC = 8'h85;
	localparam logic [7:0] SCT_OP_ACC_TO_XL = 8'h97;
	localparam logic [7:0] SCT_OP_XL_TO_ACC = 8'h9F;
	localparam logic [7:0] SCT_OP_SP_TO_IDX = 8'h95;
	localparam logic [7:0] SCT_OP_IDX_TO_SP = 8'h94;
	localparam logic [7:0] SCT_OP_TST_PG0 = 8'h3D;
	localparam logic [7:0] SCT_OP_TST_A = 8'h4D;
	localparam logic [7:0] SCT_OP_TST_X = 8'h5D;
	localparam logic [7:0] SCT_OP_TST_O8 = 8'h6D;
	localparam logic [7:0] SCT_OP_TST_PTR = 8'h7D;

	// Addressing modes of the operand.
	typedef enum logic [3:0] {
		SCT_M_IMPLIED, SCT_M_LIT, SCT_M_PAGE0, SCT_M_ABS16, SCT_M_OFF16,
		SCT_M_OFF8, SCT_M_PTR, SCT_M_SOFF8, SCT_M_SOFF16
	} sct_mode_e;

	// Total cycle count of an instruction, opcode fetch included.
	function automatic logic [3:0] sct_cycles(input logic pre, input logic [7:0] op);
		logic [3:0] n;
		n = 4'h1;
		if (pre) begin
			case (op)
				SCT_OP_SUB_O8: n = 4'h4;
				SCT_OP_SUB_O16: n = 4'h5;
				SCT_OP_TST_O8: n = 4'h4;
				default: n = 4'h2;
			endcase
		end else begin
			case (op)
				SCT_OP_SUB_LIT, SCT_OP_SUB_PTR, SCT_OP_TST_PTR: n = 4'h2;
				SCT_OP_ACC_TO_FLAGS, SCT_OP_SP_TO_IDX, SCT_OP_IDX_TO_SP: n = 4'h2;
				SCT_OP_SUB_PG0, SCT_OP_SUB_O8, SCT_OP_TST_PG0, SCT_OP_TST_O8: n = 4'h3;
				SCT_OP_SUB_ABS, SCT_OP_SUB_O16: n = 4'h4;
				SCT_OP_SOFT_TRAP: n = 4'h9;
				default: n = 4'h1;
			endcase
		end
		return n;
	endfunction : sct_cycles

	// Addressing mode of an opcode, with or without the stack prefix.
	function automatic sct_mode_e sct_mode(input logic pre, input logic [7:0] op);
		sct_mode_e m;
		m = SCT_M_IMPLIED;
		if (pre) begin
			if (op == SCT_OP_SUB_O8 || op == SCT_OP_TST_O8)
				m = SCT_M_SOFF8;
			else if (op == SCT_OP_SUB_O16)
				m = SCT_M_SOFF16;
		end else begin
			case (op)
				SCT_OP_SUB_LIT: m = SCT_M_LIT;
				SCT_OP_SUB_PG0, SCT_OP_TST_PG0: m = SCT_M_PAGE0;
				SCT_OP_SUB_ABS: m = SCT_M_ABS16;
				SCT_OP_SUB_O16: m = SCT_M_OFF16;
				SCT_OP_SUB_O8, SCT_OP_TST_O8: m = SCT_M_OFF8;
				SCT_OP_SUB_PTR, SCT_OP_TST_PTR: m = SCT_M_PTR;
				default: m = SCT_M_IMPLIED;
			endcase
		end
		return m;
	endfunction : sct_mode
endpackage : sct_pkg

/* sct_alu.sv */
// Subtract and test-against-zero unit with flag update.
module sct_alu
	import sct_pkg::*;
(
	// Operation select: 1 subtracts, 0 tests i_a against zero.
	input wire logic i_sub,
	// Operands and incoming flags.
	input wire logic [7:0] i_a,
	input wire logic [7:0] i_m,
	input wire logic [7:0] i_ccr,
	// Result and outgoing flags.
	output logic [7:0] o_res,
	output logic [7:0] o_ccr
);
	logic [8:0] diff;

	// Difference with borrow out in the top bit.
	assign diff = {1'b0, i_a} - {1'b0, (i_sub ? i_m : 8'h00)};

	// Flag update: subtract touches V, N, Z, C; test clears V and keeps C.
	always_comb begin
		o_res = diff[7:0];
		o_ccr = i_ccr;
		o_ccr[SCT_F_N] = diff[7];
		o_ccr[SCT_F_Z] = (diff[7:0] == 8'h00);
		if (i_sub) begin
			o_ccr[SCT_F_V] = (i_a[7] & ~i_m[7] & ~diff[7]) | (~i_a[7] & i_m[7] & diff[7]);
			o_ccr[SCT_F_C] = diff[8];
		end else begin
			o_ccr[SCT_F_V] = 1'b0;
		end
	end
endmodule : sct_alu

/* sct_core.sv */
// The address map and the Wishbone register port were chosen for this implementation.
module sct_core
	import sct_pkg::*;
(
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_reset,
	// Wishbone classic slave.
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// Memory and stack bus, asynchronous read.
	output logic [15:0] o_mem_addr,
	output logic o_mem_rd,
	output logic o_mem_wr,
	output logic [7:0] o_mem_wdata,
	input wire logic [7:0] i_mem_rdata
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		S_FETCH, S_PREFIX, S_OPND_HI, S_OPND_LO, S_EXEC, S_PUSH, S_VEC_HI, S_VEC_LO, S_PAD
	} sct_state_e;

	sct_state_e state_reg;
	sct_mode_e mode_reg;
	sct_mode_e dec_mode;
	logic [7:0] acc_reg;
	logic [7:0] xl_reg;
	logic [7:0] xh_reg;
	logic [7:0] ccr_reg;
	logic [15:0] sp_reg;
	logic [15:0] pc_reg;
	logic [15:0] vec_reg;
	logic [15:0] ea_reg;
	logic [7:0] hi_reg;
	logic [3:0] cnt_reg;
	logic [3:0] need_reg;
	logic [2:0] push_reg;
	logic sub_reg;
	logic pinc_reg;
	logic run_reg;
	logic pinc_en_reg;
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic [15:0] hx;
	logic [3:0] dec_need;
	logic last;
	logic dec_sub;
	logic [15:0] ea_now;
	logic [7:0] push_byte;
	logic alu_sub;
	logic [7:0] alu_a;
	logic [7:0] alu_res;
	logic [7:0] alu_ccr;
	logic bus_req;
	logic bus_wr;
	logic ptrs_wr;

	assign hx = {xh_reg, xl_reg};
	assign bus_req = i_wb_cyc & i_wb_stb & ~ack_reg;
	assign bus_wr = bus_req & i_wb_we;
	assign ptrs_wr = bus_wr & (i_wb_adr == SCT_OFF_PTRS) & (state_reg == S_FETCH) & ~run_reg;

	// Decode of the byte on the read bus, with the prefix seen in S_PREFIX.
	assign dec_mode = sct_mode(state_reg == S_PREFIX, i_mem_rdata);
	assign dec_need = sct_cycles(state_reg == S_PREFIX, i_mem_rdata);
	assign dec_sub = (i_mem_rdata[3:0] == 4'h0);

	// Last cycle of the instruction: in decode cycles the new count applies.
	assign last = (state_reg == S_FETCH || state_reg == S_PREFIX) ?
		((dec_need - 4'h1) <= cnt_reg) : ((need_reg - 4'h1) <= cnt_reg);

	// Operand address from the final operand byte, the stored high byte in 16-bit modes, and X or SP where indexed.
	always_comb begin
		case (mode_reg)
			SCT_M_ABS16: ea_now = {hi_reg, i_mem_rdata};
			SCT_M_OFF16: ea_now = {hi_reg, i_mem_rdata} + hx;
			SCT_M_OFF8: ea_now = {8'h00, i_mem_rdata} + hx;
			SCT_M_SOFF8: ea_now = sp_reg + {8'h00, i_mem_rdata};
			SCT_M_SOFF16: ea_now = sp_reg + {hi_reg, i_mem_rdata};
			default: ea_now = {8'h00, i_mem_rdata};
		endcase
	end

	// Byte pushed in each stacking cycle of the soft trap.
	always_comb begin
		case (push_reg)
			3'h0: push_byte = pc_reg[7:0];
			3'h1: push_byte = pc_reg[15:8];
			3'h2: push_byte = xl_reg;
			3'h3: push_byte = acc_reg;
			default: push_byte = ccr_reg;
		endcase
	end

	// ALU operands: a test in the fetch cycle looks at A or X, else at memory.
	always_comb begin
		alu_sub = (state_reg != S_FETCH) & sub_reg;
		if (alu_sub)
			alu_a = acc_reg;
		else if (state_reg == S_FETCH)
			alu_a = (i_mem_rdata == SCT_OP_TST_X) ? xl_reg : acc_reg;
		else
			alu_a = i_mem_rdata;
	end

	sct_alu u_alu (
		.i_sub(alu_sub),
		.i_a(alu_a),
		.i_m(i_mem_rdata),
		.i_ccr(ccr_reg),
		.o_res(alu_res),
		.o_ccr(alu_ccr)
	);

	// ------------------------------------------------------------
	// Memory bus drive
	// ------------------------------------------------------------

	// At most one access per cycle: reads at PC, the operand address, the vector, or a stack write.
	always_comb begin
		o_mem_addr = pc_reg;
		o_mem_rd = 1'b0;
		o_mem_wr = 1'b0;
		o_mem_wdata = 8'h00;
		unique case (state_reg)
			S_FETCH: o_mem_rd = run_reg;
			S_PREFIX, S_OPND_HI, S_OPND_LO: o_mem_rd = 1'b1;
			S_EXEC: begin
				o_mem_rd = 1'b1;
				o_mem_addr = ea_reg;
			end
			S_PUSH: begin
				o_mem_wr = 1'b1;
				o_mem_addr = sp_reg;
				o_mem_wdata = push_byte;
			end
			S_VEC_HI: begin
				o_mem_rd = 1'b1;
				o_mem_addr = vec_reg;
			end
			S_VEC_LO: begin
				o_mem_rd = 1'b1;
				o_mem_addr = vec_reg + 16'h0001;
			end
			S_PAD: o_mem_rd = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Instruction sequencer and programmer's registers
	// ------------------------------------------------------------

	// Executes one instruction, padding with idle cycles up to its cycle count; opcodes done in S_FETCH end there unpadded, as cnt_reg is at least 1.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_reg <= S_FETCH;
			mode_reg <= SCT_M_IMPLIED;
			acc_reg <= 8'h00;
			xl_reg <= 8'h00;
			xh_reg <= 8'h00;
			ccr_reg <= SCT_CCR_RST;
			sp_reg <= SCT_SP_RST;
			pc_reg <= SCT_PC_RST;
			ea_reg <= 16'h0000;
			hi_reg <= 8'h00;
			cnt_reg <= 4'h0;
			need_reg <= 4'h1;
			push_reg <= 3'h0;
			sub_reg <= 1'b0;
			pinc_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_reg + 4'h1;
			unique case (state_reg)
				S_FETCH: begin
					cnt_reg <= 4'h1;
					if (ptrs_wr) begin
						if (i_wb_sel[1:0] == 2'b11)
							pc_reg <= i_wb_dat[15:0];
						if (i_wb_sel[3:2] == 2'b11)
							sp_reg <= i_wb_dat[31:16];
					end else if (run_reg) begin
						pc_reg <= pc_reg + 16'h0001;
						need_reg <= dec_need;
						mode_reg <= dec_mode;
						sub_reg <= dec_sub;
						pinc_reg <= pinc_en_reg & (dec_mode == SCT_M_PTR);
						ea_reg <= hx;
						push_reg <= 3'h0;
						state_reg <= last ? S_FETCH : S_PAD;
						case (i_mem_rdata)
							SCT_OP_PREFIX: state_reg <= S_PREFIX;
							SCT_OP_SOFT_TRAP: state_reg <= S_PUSH;
							SCT_OP_ACC_TO_FLAGS: ccr_reg <= acc_reg;
							SCT_OP_FLAGS_TO_ACC: acc_reg <= ccr_reg;
							SCT_OP_ACC_TO_XL: xl_reg <= acc_reg;
							SCT_OP_XL_TO_ACC: acc_reg <= xl_reg;
							SCT_OP_SP_TO_IDX: {xh_reg, xl_reg} <= sp_reg + 16'h0001;
							SCT_OP_IDX_TO_SP: sp_reg <= hx - 16'h0001;
							SCT_OP_TST_A, SCT_OP_TST_X: ccr_reg <= alu_ccr;
							default: begin
								if (dec_mode == SCT_M_PTR)
									state_reg <= S_EXEC;
								else if (dec_mode == SCT_M_ABS16 || dec_mode == SCT_M_OFF16)
									state_reg <= S_OPND_HI;
								else if (dec_mode != SCT_M_IMPLIED)
									state_reg <= S_OPND_LO;
							end
						endcase
					end
				end
				S_PREFIX: begin
					pc_reg <= pc_reg + 16'h0001;
					need_reg <= dec_need;
					mode_reg <= dec_mode;
					sub_reg <= dec_sub;
					pinc_reg <= 1'b0;
					if (dec_mode == SCT_M_SOFF16)
						state_reg <= S_OPND_HI;
					else if (dec_mode == SCT_M_SOFF8)
						state_reg <= S_OPND_LO;
					else
						state_reg <= last ? S_FETCH : S_PAD;
				end
				S_OPND_HI: begin
					pc_reg <= pc_reg + 16'h0001;
					hi_reg <= i_mem_rdata;
					state_reg <= S_OPND_LO;
				end
				S_OPND_LO: begin
					pc_reg <= pc_reg + 16'h0001;
					ea_reg <= ea_now;
					if (mode_reg == SCT_M_LIT) begin
						acc_reg <= alu_res;
						ccr_reg <= alu_ccr;
						state_reg <= last ? S_FETCH : S_PAD;
					end else begin
						state_reg <= S_EXEC;
					end
				end
				S_EXEC: begin
					if (sub_reg)
						acc_reg <= alu_res;
					ccr_reg <= alu_ccr;
					if (pinc_reg)
						{xh_reg, xl_reg} <= hx + 16'h0001;
					state_reg <= last ? S_FETCH : S_PAD;
				end
				S_PUSH: begin
					sp_reg <= sp_reg - 16'h0001;
					push_reg <= push_reg + 3'h1;
					if (push_reg == 3'h4) begin
						ccr_reg[SCT_F_I] <= 1'b1;
						state_reg <= S_VEC_HI;
					end
				end
				S_VEC_HI: begin
					pc_reg[15:8] <= i_mem_rdata;
					state_reg <= S_VEC_LO;
				end
				S_VEC_LO: begin
					pc_reg[7:0] <= i_mem_rdata;
					state_reg <= last ? S_FETCH : S_PAD;
				end
				S_PAD: begin
					if (last)
						state_reg <= S_FETCH;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------

	// Control and trap vector registers, written byte lane by byte lane.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			run_reg <= 1'b0;
			pinc_en_reg <= 1'b0;
			vec_reg <= SCT_VEC_RST;
		end else if (bus_wr) begin
			if (i_wb_adr == SCT_OFF_CTRL && i_wb_sel[0]) begin
				run_reg <= i_wb_dat[SCT_CTRL_RUN];
				pinc_en_reg <= i_wb_dat[SCT_CTRL_PINC];
			end
			if (i_wb_adr == SCT_OFF_VEC) begin
				if (i_wb_sel[0])
					vec_reg[7:0] <= i_wb_dat[7:0];
				if (i_wb_sel[1])
					vec_reg[15:8] <= i_wb_dat[15:8];
			end
		end
	end

	// Read data and acknowledge, one cycle after the request; unmapped reads zero.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= bus_req;
			case (i_wb_adr)
				SCT_OFF_CTRL: rdat_reg <= {27'h0, state_reg == S_FETCH, 2'h0, pinc_en_reg, run_reg};
				SCT_OFF_VEC: rdat_reg <= {16'h0000, vec_reg};
				SCT_OFF_ACC: rdat_reg <= {ccr_reg, xh_reg, xl_reg, acc_reg};
				SCT_OFF_PTRS: rdat_reg <= {sp_reg, pc_reg};
				default: rdat_reg <= 32'h0000_0000;
			endcase
		end
	end

	assign o_wb_ack = ack_reg;
	assign o_wb_dat = rdat_reg;
endmodule : sct_core

/* sct_core_asserts.sv */
// ------------------------------------------------------------
// Port-level checks of the core
// ------------------------------------------------------------
module sct_core_asserts
	import sct_pkg::*;
(
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_reset,
	// Wishbone side.
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	// Memory and stack side.
	input wire logic [15:0] o_mem_addr,
	input wire logic o_mem_rd,
	input wire logic o_mem_wr,
	input wire logic [7:0] o_mem_wdata,
	input wire logic [7:0] i_mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// All checks run on the core clock and rest while reset is high.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack held longer than one cycle");
	chk_ack_answer: assert property ((i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
		else $error("request not answered in one cycle");
	chk_ack_idle: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
		else $error("ack without a request");
	chk_unmapped_zero: assert property ((o_wb_ack && !$past(i_wb_we) && $past(i_wb_adr) > 8'h0C) |-> o_wb_dat == 32'h0)
		else $error("unmapped read not zero");
	chk_bus_excl: assert property (!(o_mem_rd && o_mem_wr))
		else $error("read and write in one cycle");
	chk_push_run: assert property ($rose(o_mem_wr) |-> o_mem_wr [*5] ##1 (o_mem_rd && !o_mem_wr))
		else $error("trap push run not five writes then a read");
	chk_push_down: assert property (($past(o_mem_wr) && o_mem_wr) |-> o_mem_addr == $past(o_mem_addr) - 16'h0001)
		else $error("stack pointer not stepping down");
	chk_push_pcl: assert property ($rose(o_mem_wr) |-> o_mem_wdata == 8'($past(o_mem_addr) + 16'h0001))
		else $error("first push not the advanced low counter byte");
	chk_push_pch: assert property ($rose(o_mem_wr) |=> o_mem_wdata == 8'(($past(o_mem_addr, 2) + 16'h0001) >> 8))
		else $error("second push not the high counter byte");
	chk_vec_fetch: assert property ($fell(o_mem_wr) |-> ##1 (o_mem_rd && o_mem_addr == $past(o_mem_addr) + 16'h0001)
		##1 !(o_mem_rd || o_mem_wr) ##1 (o_mem_addr == {$past(i_mem_rdata, 3), $past(i_mem_rdata, 2)}))
		else $error("vector not read high then low and jumped to");
endmodule : sct_core_asserts

/* sct_mem_model.sv */
// Program memory and stack with combinational read.
module sct_mem_model (
	// Clock.
	input wire logic i_clk,
	// Memory bus from the core.
	input wire logic [15:0] i_addr,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:65535];
	logic [7:0] last_reg = 8'h00;
	// Pushes land at the rising edge; the last read value is kept.
	always @(posedge i_clk) begin
		if (i_wr) begin
			mem[i_addr] <= i_wdata;
		end
		if (i_rd) begin
			last_reg <= mem[i_addr];
		end
	end
	// An idle bus shows the inverse of the last value, never a stale copy.
	assign o_rdata = i_rd ? mem[i_addr] : ~last_reg;
endmodule : sct_mem_model

/* sct_core_tb.sv */
module sct_core_tb;
	import sct_pkg::*;
	timeunit 1ns;
	// Finer precision keeps the 12.5 ns half period exact.
	timeprecision 100ps;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_wb_cyc = 1'b0;
	logic i_wb_stb = 1'b0;
	logic i_wb_we = 1'b0;
	logic [7:0] i_wb_adr = 8'h00;
	logic [31:0] i_wb_dat = 32'h0;
	logic [3:0] i_wb_sel = 4'h0;
	logic [31:0] o_wb_dat;
	logic o_wb_ack, o_mem_rd, o_mem_wr;
	logic [15:0] o_mem_addr;
	logic [7:0] o_mem_wdata, i_mem_rdata;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [63:0] rd_q[$];
	logic [23:0] wr_q[$];

	sct_core dut (.i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
		.i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
		.o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata),
		.i_mem_rdata(i_mem_rdata));
	sct_mem_model mem_i (.i_clk(i_clk), .i_addr(o_mem_addr), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
		.i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));

	// 40 MHz clock.
	always #12.5 i_clk = ~i_clk;

	// ------------------------------------------------------------
	// Comparison and closing
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check

	task automatic test_done();
		$display("checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done

	// Subtract with flag update as the bench expects it.
	function automatic logic [15:0] sub_f(input logic [7:0] a, m, f);
		logic [7:0] r;
		r = a - m;
		f[SCT_F_V] = (a[7] & ~m[7] & ~r[7]) | (~a[7] & m[7] & r[7]);
		f[SCT_F_N] = r[7];
		f[SCT_F_Z] = (r == 8'h00);
		f[SCT_F_C] = (a < m);
		return {r, f};
	endfunction : sub_f

	// One classic Wishbone cycle; the request holds until ack is sampled.
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge i_clk);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= we;
		i_wb_adr <= adr;
		i_wb_dat <= dat;
		i_wb_sel <= 4'hF;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 50);
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		@(posedge i_clk);
	endtask : wb

	task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] mask);
		rd_q.push_back({exp, mask});
		wb(1'b0, adr, 32'h0);
	endtask : rd

	// Runs one program with random operands and notes every expected result.
	task automatic run_prog();
		logic [7:0] r1, r2, r3, a, c;
		logic [7:0] prog [22];
		logic [15:0] t;
		int n;
		@(posedge i_clk);
		i_reset <= 1'b1;
		@(posedge i_clk);
		i_reset <= 1'b0;
		r1 = 8'($urandom);
		r2 = 8'($urandom);
		r3 = 8'($urandom);
		prog = '{8'hA0, r1, 8'hC0, 8'h01, 8'h00, 8'h85, 8'h97, 8'h9F, 8'h4D, 8'h95, 8'hF0,
			8'hD0, 8'h00, 8'h01, 8'h94, 8'h9E, 8'hE0, 8'h02, 8'h84, 8'h3D, 8'h02, 8'h83};
		for (int i = 0; i < 65536; i++) mem_i.mem[i] = 8'h9D;
		for (int i = 0; i < 22; i++) mem_i.mem[i] = prog[i];
		mem_i.mem[16'h0100] = r2;
		mem_i.mem[16'h0102] = r3;
		mem_i.mem[16'hFFFC] = 8'h02;
		mem_i.mem[16'hFFFD] = 8'h00;
		t = sub_f(8'h00, r1, SCT_CCR_RST);
		t = sub_f(t[15:8], r2, t[7:0]);
		a = t[7:0];
		c = {1'b0, a[6:3], a[7], a == 8'h00, a[0]};
		t = sub_f(a, r2, c);
		t = sub_f(t[15:8], r3, t[7:0]);
		t = sub_f(t[15:8], r3, t[7:0]);
		a = t[15:8];
		c = (a & 8'h79) | 8'h04;
		wr_q = '{{16'h0100, 8'h16}, {16'h00FF, 8'h00}, {16'h00FE, 8'h01}, {16'h00FD, a}, {16'h00FC, c}};
		wb(1'b1, SCT_OFF_CTRL, 32'h3);
		n = 0;
		while (wr_q.size() > 0 && n < 300) begin
			@(posedge i_clk);
			n++;
		end
		wb(1'b1, SCT_OFF_CTRL, 32'h0);
		rd(SCT_OFF_ACC, {c | 8'h08, 8'h01, 8'h01, a}, 32'hFFFFFFFF);
		rd(SCT_OFF_PTRS, {16'h00FB, 16'h0000}, 32'hFFFF0000);
	endtask : run_prog

	// Compares each read answer and each stack push with the oldest note.
	always @(posedge i_clk) begin
		cycles++;
		if (o_wb_ack === 1'b1 && i_wb_we === 1'b0) begin
			if (rd_q.size() > 0) begin
				check("read data", rd_q[0][63:32], o_wb_dat & rd_q[0][31:0]);
				void'(rd_q.pop_front());
			end
		end
		if (o_mem_wr === 1'b1) begin
			if (wr_q.size() > 0) begin
				check("stack push", {8'h00, wr_q[0]}, {8'h00, o_mem_addr, o_mem_wdata});
				void'(wr_q.pop_front());
			end else begin
				check("stray write", 32'h0, 32'h1);
			end
		end
		if (cycles > 5000) begin
			mismatches++;
			test_done();
		end
	end

	// Main sequence: reset values, unmapped read, then three programs.
	initial begin
		void'($urandom(32'hA29B));
		repeat (16) @(posedge i_clk);
		i_reset <= 1'b0;
		rd(SCT_OFF_ACC, {SCT_CCR_RST, 24'h0}, 32'hFFFFFFFF);
		rd(SCT_OFF_PTRS, {SCT_SP_RST, SCT_PC_RST}, 32'hFFFFFFFF);
		rd(SCT_OFF_VEC, {16'h0, SCT_VEC_RST}, 32'hFFFFFFFF);
		rd(8'h10, 32'h0, 32'hFFFFFFFF);
		$display("test reset values done");
		for (int k = 0; k < 3; k++) begin
			run_prog();
			$display("test program %0d done", k);
		end
		test_done();
	end
endmodule : sct_core_tb

bind sct_core sct_core_asserts chk (.i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
	.i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_mem_addr(o_mem_addr),
	.o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata));
